// ### hw/ota_pkg.sv
// shared constants and carrier types for the dual-bank update sequencer
package ota_pkg;
    localparam logic [10:0] ID_START       = 11'h100;
    localparam logic [10:0] ID_DOWNLOAD    = 11'h110;
    localparam logic [10:0] ID_DATA_REQ    = 11'h111;
    localparam logic [10:0] ID_WRITE_END   = 11'h121;
    localparam logic [7:0]  BYTE_START     = 8'h00;
    localparam logic [7:0]  BYTE_DATA_REQ  = 8'h11;
    localparam logic [7:0]  BYTE_WRITE_END = 8'h22;
    localparam int          NOM_RATE_BPS   = 1000000;
    localparam int          DATA_RATE_BPS  = 2000000;
    localparam int          FRAME_BYTES    = 64;
    localparam int          FRAMES_PER_BLK = 8;
    localparam int          BLOCK_BYTES    = FRAME_BYTES * FRAMES_PER_BLK;
    localparam int          TOTAL_BYTES    = 96 * 1024;
    localparam int          BLOCKS_TOTAL   = TOTAL_BYTES / BLOCK_BYTES;
    localparam logic [7:0]  LAST_BLOCK     = 8'(BLOCKS_TOTAL - 1);
    localparam logic [2:0]  LAST_FRAME     = 3'(FRAMES_PER_BLK - 1);
    localparam logic [7:0]  BLOCK_RST      = 8'h00;
    localparam logic [2:0]  FRAME_RST      = 3'h0;
    localparam logic [1:0]  MODE_PINS_UB   = 2'h0;
    localparam logic [1:0]  STMSEL_UB      = 2'h1;
    localparam logic [1:0]  MAP_DOUBLE     = 2'h0;
    localparam logic [1:0]  FCMD_NONE      = 2'h0;
    localparam logic [1:0]  FCMD_ERASE     = 2'h1;
    localparam logic [1:0]  FCMD_PROGRAM   = 2'h2;
    localparam logic [1:0]  FCMD_OPTION    = 2'h3;

    typedef enum logic [8:0] {
        ST_IDLE   = 9'h001,
        ST_AUTH   = 9'h002,
        ST_ERASE  = 9'h004,
        ST_REQ    = 9'h008,
        ST_RECV   = 9'h010,
        ST_PROG   = 9'h020,
        ST_OPTION = 9'h040,
        ST_END    = 9'h080,
        ST_FAIL   = 9'h100
    } seq_e;

    typedef struct packed {
        logic [10:0]  id;
        logic [511:0] data;
    } frame_s;

    typedef struct packed {
        logic         valid;
        logic [1:0]   cmd;
        logic         bank;
        logic [7:0]   block;
        logic [2:0]   frame;
        logic [511:0] data;
    } fcmd_s;

    typedef struct packed {
        logic valid;
        logic [10:0] id;
        logic [7:0]  byte0;
    } txf_s;
endpackage

// ### hw/ota_dual_bank_flash_update.sv
// dual-bank over-the-air update sequencer with download frame buffer
`timescale 1ns/100ps
// How it works
// - pins 000, option 01 select user boot
// - map option 00 selects double map
// - after reset boot bank then run app
// - erase and program only inactive bank
// - app runs; update waits start command
// - compare 256-bit stored ID with inputs
// - erase inactive area after good ID
// - request block, take eight 64-byte frames
// - program each 512-byte block
// - stop after 96K bytes written
// - write next boot bank to option
// - fixed frame IDs and command bytes
// - send write end when finished
// - link runs 1M nominal, 2M data
module ota_dual_bank_flash_update
    import ota_pkg::*;
(
    input  wire logic         mclk,
    input  wire logic         arst_n,
    input  wire logic         mode_pin_hi,
    input  wire logic         mode_pin_lo,
    input  wire logic         test_reset_pin,
    input  wire logic         start_mode_sel_hi,
    input  wire logic         start_mode_sel_lo,
    input  wire logic         map_sel_hi,
    input  wire logic         map_sel_lo,
    input  wire logic         boot_bank_opt,
    input  wire logic [255:0] stored_id,
    input  wire logic [255:0] auth_id_input,
    input  wire frame_s       rx_frame,
    input  wire logic         rx_valid,
    output logic              rx_ready,
    output txf_s              tx_frame,
    input  wire logic         tx_ready,
    output fcmd_s             flash_cmd,
    input  wire logic         flash_done,
    output logic              user_boot_mode,
    output logic              double_map,
    output logic              app_run,
    output logic              active_bank,
    output logic              busy,
    output logic              auth_fail,
    output logic              update_done
);
    typedef struct packed {
        seq_e         st;
        logic         booted;
        logic         ubm;
        logic         dmap;
        logic         bank;
        logic [7:0]   block;
        logic [2:0]   frame;
        logic [511:0] b0;
        logic [511:0] b1;
        logic [1:0]   cnt;
        logic         wp;
        logic         rp;
        logic         fail;
        logic         done;
        logic         busy;
        logic         wait_ack;
        txf_s         tx;
        fcmd_s        fc;
    } state_s;

    state_s s_q;
    state_s s_d;

    localparam state_s S_RST = '{st: ST_IDLE, block: BLOCK_RST, frame: FRAME_RST,
                                 tx: '0, fc: '0, default: '0};

    function automatic logic is_id(input logic [10:0] got, input logic [10:0] want);
        return got == want;
    endfunction

    // two-entry buffer: accept while not full, or always in idle; pop when sequencer consumes
    logic buf_empty;
    logic push;
    logic pop;
    logic [511:0] head;
    always_comb
    begin
        buf_empty = s_q.cnt == 2'h0;
        head      = s_q.rp ? s_q.b1 : s_q.b0;
        push      = rx_valid && rx_ready && is_id(rx_frame.id, ID_DOWNLOAD);
        pop       = (s_q.st == ST_RECV) && !buf_empty;
    end

    always_comb
    begin
        s_d = s_q;
        if (!s_q.booted)
        begin
            // strap pins sampled on first clock after reset release
            s_d.booted = 1'b1;
            s_d.ubm  = {mode_pin_hi, mode_pin_lo} == MODE_PINS_UB && !test_reset_pin &&
                       {start_mode_sel_hi, start_mode_sel_lo} == STMSEL_UB;
            s_d.dmap = {map_sel_hi, map_sel_lo} == MAP_DOUBLE;
            s_d.bank = boot_bank_opt;
        end
        if (push)
        begin
            if (s_q.wp)
                s_d.b1 = rx_frame.data;
            else
                s_d.b0 = rx_frame.data;
            s_d.wp = !s_q.wp;
        end
        if (s_q.tx.valid && tx_ready)
            s_d.tx.valid = 1'b0;
        if (s_q.fc.valid)
            s_d.fc.valid = 1'b0;
        // one flash operation in flight; a new issue below wins over done
        if (flash_done)
            s_d.wait_ack = 1'b0;
        case (s_q.st)
            ST_IDLE:
            begin
                // start frame is consumed here; download frames still go into the buffer, other ids are dropped
                if (s_q.booted && rx_valid && is_id(rx_frame.id, ID_START) &&
                    rx_frame.data[511:504] == BYTE_START)
                begin
                    s_d.st   = ST_AUTH;
                    s_d.fail = 1'b0;
                    s_d.done = 1'b0;
                end
            end
            ST_AUTH:
            begin
                if (stored_id == auth_id_input)
                begin
                    s_d.st = ST_ERASE;
                    s_d.fc = '{valid: 1'b1, cmd: FCMD_ERASE, bank: !s_q.bank,
                               block: BLOCK_RST, frame: FRAME_RST, data: '0};
                    s_d.wait_ack = 1'b1;
                end
                else
                    s_d.st = ST_FAIL;
            end
            ST_ERASE:
            begin
                if (flash_done)
                begin
                    s_d.st = ST_REQ;
                    s_d.block = BLOCK_RST;
                end
            end
            ST_REQ:
            begin
                if (!s_q.tx.valid)
                begin
                    s_d.tx = '{valid: 1'b1, id: ID_DATA_REQ, byte0: BYTE_DATA_REQ};
                    s_d.frame = FRAME_RST;
                    s_d.st = ST_RECV;
                end
            end
            ST_RECV:
            begin
                if (pop)
                begin
                    s_d.fc = '{valid: 1'b1, cmd: FCMD_PROGRAM, bank: !s_q.bank,
                               block: s_q.block, frame: s_q.frame, data: head};
                    s_d.rp = !s_q.rp;
                    s_d.wait_ack = 1'b1;
                    s_d.st = ST_PROG;
                end
            end
            ST_PROG:
            begin
                if (flash_done)
                begin
                    if (s_q.frame != LAST_FRAME)
                    begin
                        s_d.frame = s_q.frame + 3'h1;
                        s_d.st = ST_RECV;
                    end
                    else if (s_q.block == LAST_BLOCK)
                    begin
                        s_d.st = ST_OPTION;
                        s_d.fc = '{valid: 1'b1, cmd: FCMD_OPTION, bank: !s_q.bank,
                                   block: BLOCK_RST, frame: FRAME_RST, data: '0};
                        s_d.wait_ack = 1'b1;
                    end
                    else
                    begin
                        s_d.block = s_q.block + 8'h01;
                        s_d.st = ST_REQ;
                    end
                end
            end
            ST_OPTION:
            begin
                if (flash_done)
                    s_d.st = ST_END;
            end
            ST_END:
            begin
                if (!s_q.tx.valid)
                begin
                    s_d.tx = '{valid: 1'b1, id: ID_WRITE_END, byte0: BYTE_WRITE_END};
                    s_d.done = 1'b1;
                    s_d.st = ST_IDLE;
                end
            end
            ST_FAIL:
            begin
                s_d.fail = 1'b1;
                s_d.st = ST_IDLE;
            end
            default:
                s_d.st = ST_IDLE;
        endcase
        s_d.cnt = s_q.cnt + 2'(push) - 2'(pop);
        // busy is kept as a flop so the output needs no decode
        s_d.busy = s_d.st != ST_IDLE;
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            s_q <= S_RST;
        else
            s_q <= s_d;
    end

    // ready is a flop so the output comes straight from state; idle always
    // takes frames, so the reset value matches the idle state
    // dropping ready after a push into one entry costs a bubble, never a word
    logic rdy_q;
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            rdy_q <= 1'b1;
        else
            rdy_q <= (s_d.st == ST_IDLE) ||
                     ((s_d.cnt != 2'h2) && !(s_d.cnt == 2'h1 && !pop && push));
    end

    always_comb
    begin
        rx_ready       = rdy_q;
        tx_frame       = s_q.tx;
        flash_cmd      = s_q.fc;
        user_boot_mode = s_q.ubm;
        double_map     = s_q.dmap;
        app_run        = s_q.booted;
        active_bank    = s_q.bank;
        busy           = s_q.busy;
        auth_fail      = s_q.fail;
        update_done    = s_q.done;
    end

    // id check outcomes: a mismatch gives no flash pulse and then the flag
    sequence bad_id_seq;
        s_q.st == ST_AUTH && stored_id != auth_id_input;
    endsequence
    sequence fail_flag_seq;
        !flash_cmd.valid ##1 auth_fail;
    endsequence
    sequence good_id_seq;
        s_q.st == ST_AUTH && stored_id == auth_id_input;
    endsequence
    sequence erase_pulse_seq;
        flash_cmd.valid && flash_cmd.cmd == FCMD_ERASE;
    endsequence

    a_erase_other_bank: assert property (@(posedge mclk) disable iff (!arst_n)
        flash_cmd.valid |-> flash_cmd.bank != active_bank)
        else $error("flash command hit active bank");
    a_fail_no_erase: assert property (@(posedge mclk) disable iff (!arst_n)
        bad_id_seq |=> fail_flag_seq)
        else $error("erase after failed id");
    a_auth_erase: assert property (@(posedge mclk) disable iff (!arst_n)
        good_id_seq |=> erase_pulse_seq)
        else $error("no erase after good id");
    a_start_only: assert property (@(posedge mclk) disable iff (!arst_n)
        $rose(busy) |-> $past(rx_valid) && $past(rx_frame.id) == ID_START)
        else $error("update began without start");
    a_req_frame: assert property (@(posedge mclk) disable iff (!arst_n)
        tx_frame.valid && tx_frame.id == ID_DATA_REQ |-> tx_frame.byte0 == BYTE_DATA_REQ)
        else $error("bad request byte");
    a_end_byte: assert property (@(posedge mclk) disable iff (!arst_n)
        tx_frame.valid && tx_frame.id == ID_WRITE_END |-> tx_frame.byte0 == BYTE_WRITE_END)
        else $error("bad write end byte");
    a_prog_limit: assert property (@(posedge mclk) disable iff (!arst_n)
        flash_cmd.valid && flash_cmd.cmd == FCMD_PROGRAM |-> flash_cmd.block <= LAST_BLOCK)
        else $error("programmed beyond 96K");
    a_end_sent: assert property (@(posedge mclk) disable iff (!arst_n)
        $rose(update_done) |-> tx_frame.valid && tx_frame.id == ID_WRITE_END)
        else $error("no write end frame");
    a_bank_stable: assert property (@(posedge mclk) disable iff (!arst_n)
        s_q.booted && $past(s_q.booted) |-> $stable(active_bank))
        else $error("active bank changed");
    a_one_flash_op: assert property (@(posedge mclk) disable iff (!arst_n)
        s_q.wait_ack && !flash_done |=> !flash_cmd.valid)
        else $error("flash command while one is pending");
    a_buf_no_overrun: assert property (@(posedge mclk) disable iff (!arst_n)
        push |-> s_q.cnt != 2'h2)
        else $error("download buffer overrun");
endmodule // ota_dual_bank_flash_update

// ### tb/ota_host_model.sv
// update host model: starts updates, answers block requests
`timescale 1ns/100ps
module ota_host_model
    import ota_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic [7:0] start_byte,
    input  wire logic [7:0] starts,
    input  wire txf_s       tx_frame,
    input  wire logic       rx_ready,
    output frame_s          rx_frame,
    output logic            rx_valid,
    output logic            tx_ready,
    output logic [7:0]      n_end
);
    logic [7:0] sent;
    logic [7:0] seq;

    // valid stays up from one accepted frame to the next; release drops it
    task automatic send(input logic [10:0] id, input logic [511:0] data);
        rx_frame = '{id: id, data: data};
        rx_valid = 1'b1;
        do @(posedge mclk); while (rx_ready !== 1'b1);
        @(negedge mclk);
    endtask

    task automatic release_bus;
        rx_valid = 1'b0;
        rx_frame = ~rx_frame; // released lines never keep the last word
    endtask

    initial
    begin
        {rx_valid, tx_ready, sent, seq, n_end} = '0;
        rx_frame = '1;
        forever
        begin
            @(negedge mclk);
            tx_ready = 1'b0;
            if (sent != starts)
            begin
                sent = starts;
                send(ID_START, {start_byte, 504'h0});
                release_bus();
            end
            else if (tx_frame.valid === 1'b1)
            begin
                tx_ready = 1'b1;
                if (tx_frame.id === ID_WRITE_END && tx_frame.byte0 === BYTE_WRITE_END)
                    n_end = n_end + 8'h01;
                if (tx_frame.id === ID_DATA_REQ && tx_frame.byte0 === BYTE_DATA_REQ)
                begin
                    @(negedge mclk);
                    tx_ready = 1'b0;
                    // frames go back to back so a slow flash fills the buffer
                    repeat (FRAMES_PER_BLK)
                    begin
                        send(ID_DOWNLOAD, {64{seq}});
                        seq = seq + 8'h01;
                    end
                    release_bus();
                end
            end
        end
    end
endmodule // ota_host_model

// ### tb/ota_dual_bank_flash_update_tb.sv
// self-checking bench for the dual-bank update sequencer
`timescale 1ns/100ps
module ota_dual_bank_flash_update_tb
    import ota_pkg::*;
;
    logic mclk = 1'b0, arst_n = 1'b0, boot_bank = 1'b0, flash_done = 1'b0, p = 1'b0;
    logic [6:0] strp = 7'h04;
    logic [255:0] stored_id = {8'h00, {31{8'hFF}}};
    logic [255:0] auth_in = '0;
    logic [7:0] start_byte = 8'h00, starts = 8'h00, n_end, seq = 8'h00;
    frame_s rx_frame;
    txf_s tx_frame;
    fcmd_s flash_cmd;
    logic rx_valid, rx_ready, tx_ready, ubm, dbl, app_run, active_bank, busy, auth_fail, done;
    int n_errors = 0, cmp_count = 0, fdel = 2, fcnt = 0;
    int n_erase = 0, n_prog = 0, n_opt = 0, refused = 0;

    always #12.5 mclk = ~mclk;

    ota_dual_bank_flash_update u_ota_dual_bank_flash_update (
        .mclk(mclk), .arst_n(arst_n), .mode_pin_hi(strp[6]), .mode_pin_lo(strp[5]),
        .test_reset_pin(strp[4]), .start_mode_sel_hi(strp[3]), .start_mode_sel_lo(strp[2]),
        .map_sel_hi(strp[1]), .map_sel_lo(strp[0]), .boot_bank_opt(boot_bank),
        .stored_id(stored_id), .auth_id_input(auth_in), .rx_frame(rx_frame),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_frame(tx_frame), .tx_ready(tx_ready),
        .flash_cmd(flash_cmd), .flash_done(flash_done), .user_boot_mode(ubm),
        .double_map(dbl), .app_run(app_run), .active_bank(active_bank), .busy(busy),
        .auth_fail(auth_fail), .update_done(done));

    ota_host_model u_ota_host_model (
        .mclk(mclk), .start_byte(start_byte), .starts(starts), .tx_frame(tx_frame),
        .rx_ready(rx_ready), .rx_frame(rx_frame), .rx_valid(rx_valid),
        .tx_ready(tx_ready), .n_end(n_end));

    task automatic chk(input string what, input logic [511:0] exp, input logic [511:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask

    task automatic print_verdict;
        $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic rst(input logic [6:0] s, input logic b);
        @(negedge mclk);
        strp = s;
        boot_bank = b;
        arst_n = 1'b0;
        repeat (5) @(negedge mclk);
        arst_n = 1'b1;
        repeat (3) @(negedge mclk);
    endtask

    // flash stand-in: answers every command after fdel cycles
    always @(negedge mclk)
    begin
        flash_done <= 1'b0;
        if (rx_valid === 1'b1 && rx_ready === 1'b0)
            refused++;
        if (flash_cmd.valid === 1'b1)
        begin
            fcnt = fdel;
            chk("target bank", 512'(!p), 512'(flash_cmd.bank));
            case (flash_cmd.cmd)
                FCMD_ERASE:
                begin
                    n_erase++;
                    chk("programs before erase", 512'h0, 512'(n_prog));
                end
                FCMD_PROGRAM:
                begin
                    chk("block frame", 512'(n_prog),
                        512'({flash_cmd.block, flash_cmd.frame}));
                    chk("program data", {64{seq}}, flash_cmd.data);
                    n_prog++;
                    seq = seq + 8'h01;
                end
                default:
                    n_opt++;
            endcase
        end
        else if (fcnt > 0)
        begin
            fcnt = fcnt - 1;
            if (fcnt == 0)
                flash_done <= 1'b1;
        end
    end

    initial
    begin
        repeat (100000) @(posedge mclk);
        n_errors++;
        print_verdict();
    end

    initial
    begin
        for (int i = 0; i < 7; i++)
        begin
            rst(7'h04 ^ (7'h01 << i), 1'b0);
            chk("user boot", 512'(i < 2), 512'(ubm));
            chk("double map", 512'(i >= 2), 512'(dbl));
        end
        rst(7'h04, 1'b0);
        chk("app run", 512'h1, 512'(app_run));
        start_byte = 8'h5A;
        starts++;
        repeat (30) @(negedge mclk);
        chk("busy on bad start", 512'h0, 512'(busy));
        start_byte = BYTE_START;
        auth_in = stored_id ^ 256'h1;
        starts++;
        for (int i = 0; i < 30 && auth_fail !== 1'b1; i++) @(negedge mclk);
        chk("auth fail", 512'h1, 512'(auth_fail));
        repeat (30) @(negedge mclk);
        chk("flash after bad id", 512'h0, 512'(n_erase + n_prog + n_opt));
        for (int k = 0; k < 2; k++)
        begin
            p = k[0];
            fdel = k ? 20 : 2;
            rst(7'h04, p);
            chk("active bank", 512'(p), 512'(active_bank));
            {n_erase, n_prog, n_opt, refused} = '0;
            auth_in = stored_id;
            starts++;
            for (int i = 0; i < 60000 && done !== 1'b1; i++) @(negedge mclk);
            // let the host count the write end frame before looking
            repeat (2) @(negedge mclk);
            chk("update done", 512'h1, 512'(done));
            chk("erases", 512'h1, 512'(n_erase));
            chk("programs", 512'(TOTAL_BYTES / FRAME_BYTES), 512'(n_prog));
            chk("option writes", 512'h1, 512'(n_opt));
            chk("write ends", 512'(k + 1), 512'(n_end));
            chk("app during update", 512'h1, 512'(app_run));
            if (k == 1)
                chk("buffer refused", 512'h1, 512'(refused != 0));
        end
        print_verdict();
    end
endmodule // ota_dual_bank_flash_update_tb
